// *** psl_bus_master.sv ***
/* Fieldbus master model for the parameter port.
   Assumes the bench clock and one-cycle strobes. */
`timescale 1ns/1ns
module psl_bus_master (
	input wire logic clk,
	input wire logic paramAck,
	input wire logic paramErr,
	input wire logic [31:0] paramRdData,
	output logic [15:0] paramAddr,
	output logic [31:0] paramWrData,
	output logic paramWr,
	output logic paramRd
);
	initial begin
		paramAddr = 16'h0000;
		paramWrData = 32'h00000000;
		paramWr = 1'b0;
		paramRd = 1'b0;
	end
	// one cycle only: a longer strobe repeats the access
	task automatic access(input logic w, input logic [15:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e,
		output logic ok);
		int n;
		ok = 1'b0;
		q = 32'h00000000;
		e = 1'b0;
		@(negedge clk);
		paramAddr = a;
		paramWrData = d;
		paramWr = w;
		paramRd = !w;
		@(negedge clk);
		paramWr = 1'b0;
		paramRd = 1'b0;
		// released data must not look still valid
		paramWrData = ~d;
		for (n = 0; n < 4; n++) begin
			if (!ok && paramAck === 1'b1) begin
				ok = 1'b1;
				q = paramRdData;
				e = paramErr;
			end
			if (!ok)
				@(negedge clk);
		end
	endtask : access
endmodule : psl_bus_master

// *** psl_limit_check.sv ***
/*
 * Software limit comparator.
 * Assumes pos and limits are relative to the current zero point.
 */
`timescale 1ns/1ns
module psl_limit_check
	import psl_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	psl_limit_if.chk lim
);
	// plain signed compare: limits live in the same frame as pos
	always_comb begin
		lim.tripPos = lim.refOk && lim.enable[EN_POS_BIT] &&
			($signed(lim.pos) >= $signed(lim.limPos));
		lim.tripNeg = lim.refOk && lim.enable[EN_NEG_BIT] &&
			($signed(lim.pos) <= $signed(lim.limNeg));
	end

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_trip_needs_ref: assert property (
		(lim.tripPos || lim.tripNeg) |-> lim.refOk)
		else $error("soft limit tripped without valid reference");
	a_trip_pos_cmp: assert property (
		(lim.refOk && lim.enable[EN_POS_BIT] &&
		$signed(lim.pos) > $signed(lim.limPos)) |-> lim.tripPos)
		else $error("positive soft limit missed");
endmodule : psl_limit_check

// *** psl_limit_if.sv ***
/*
 * Carrier between the position logic and the software limit checker.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/1ns
interface psl_limit_if;
	logic [31:0] pos;
	logic [31:0] limPos;
	logic [31:0] limNeg;
	logic [15:0] enable;
	logic refOk;
	logic tripPos;
	logic tripNeg;
	modport top (output pos, limPos, limNeg, enable, refOk,
		input tripPos, tripNeg);
	modport chk (input pos, limPos, limNeg, enable, refOk,
		output tripPos, tripNeg);
endinterface : psl_limit_if

// *** psl_pkg.sv ***
/*
 * Shared constants and types for the position setting and limit block.
 * Assumes parameter addresses are 16-bit word numbers on the fieldbus.
 */
package psl_pkg;

	// parameter addresses
	localparam logic [15:0] ADDR_SWL_EN = 16'h0606;
	localparam logic [15:0] ADDR_SWL_POS = 16'h0608;
	localparam logic [15:0] ADDR_SWL_NEG = 16'h060A;
	localparam logic [15:0] ADDR_HOME_SET = 16'h1B2C;
	localparam logic [15:0] ADDR_REF_POS = 16'h1E18;
	localparam logic [15:0] ADDR_ACT_POS = 16'h1E1A;
	localparam logic [15:0] ADDR_LATCHED = 16'h1E1C;

	// reset values
	localparam logic [15:0] SWL_EN_RST = 16'h0000;
	localparam logic [31:0] SWL_POS_RST = 32'h7FFFFFFF;
	localparam logic [31:0] SWL_NEG_RST = 32'h80000000;
	localparam logic [31:0] HOME_SET_RST = 32'h00000000;
	localparam logic [31:0] POS_RST = 32'h00000000;

	// positioning range under default scaling
	localparam logic signed [32:0] POS_MIN = 33'h1C0000000;
	localparam logic signed [32:0] POS_MAX = 33'h03FFFFFFF;

	localparam logic [7:0] HOME_BY_SET = 8'h23;

	// enable field and latched status bit positions
	localparam int EN_POS_BIT = 0;
	localparam int EN_NEG_BIT = 1;
	localparam int LATCH_HW_BIT = 1;
	localparam int LATCH_SW_BIT = 2;

	typedef enum logic [1:0] {
		PSL_MODE_OTHER = 2'b00,
		PSL_MODE_PP = 2'b01,
		PSL_MODE_JOG = 2'b10,
		PSL_MODE_HOMING = 2'b11
	} psl_mode_t;

	function automatic logic psl_in_range(input logic signed [32:0] v);
		return (v >= POS_MIN) && (v <= POS_MAX);
	endfunction : psl_in_range

	function automatic logic signed [32:0] psl_ext(input logic [31:0] v);
		return {v[31], v};
	endfunction : psl_ext

endpackage : psl_pkg

// *** psl_position_limits.sv ***
/*
 * Position keeping, homing by position setting, range and limit guard.
 * Assumes step inputs come from logic on clk; limit pins are async,
 * active low.
 */
`timescale 1ns/1ns
module psl_position_limits
	import psl_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [15:0] paramAddr,
	input wire logic [31:0] paramWrData,
	input wire logic paramWr,
	input wire logic paramRd,
	output logic [31:0] paramRdData,
	output logic paramAck,
	output logic paramErr,
	input wire logic [7:0] homingMethodSelect,
	input wire logic homingStart,
	input wire logic motorStandstill,
	input wire psl_mode_t opMode,
	input wire logic moveStart,
	input wire logic moveRelative,
	input wire logic [31:0] moveDistance,
	input wire logic refStep,
	input wire logic refDir,
	input wire logic actStep,
	input wire logic actDir,
	input wire logic limPosPin_n,
	input wire logic limNegPin_n,
	input wire logic [15:0] latchClear,
	output logic referenceOk,
	output logic stopPositive,
	output logic stopNegative,
	output logic [15:0] latchedSignalStatus,
	output logic homingDone,
	output logic homingRefused,
	output logic moveZeroSet
);
	typedef struct packed {
		logic [15:0] swlEnable;
		logic [31:0] swlPos;
		logic [31:0] swlNeg;
		logic [31:0] homeSet;
		logic [31:0] refPos;
		logic [31:0] actPos;
		logic refOk;
		logic [15:0] latched;
		logic stopPos;
		logic stopNeg;
		logic [31:0] rdData;
		logic ack;
		logic err;
		logic homeDone;
		logic homeRef;
		logic zeroSet;
	} psl_state_t;

	localparam psl_state_t STATE_RST = '{
		swlEnable: SWL_EN_RST, swlPos: SWL_POS_RST, swlNeg: SWL_NEG_RST,
		homeSet: HOME_SET_RST, refPos: POS_RST, actPos: POS_RST,
		refOk: 1'b0, latched: 16'h0000, stopPos: 1'b0, stopNeg: 1'b0,
		rdData: 32'h00000000, ack: 1'b0, err: 1'b0, homeDone: 1'b0,
		homeRef: 1'b0, zeroSet: 1'b0};

	psl_state_t r_reg;
	psl_state_t r_next;

	logic [1:0] pinSync;
	logic hwPos;
	logic hwNeg;
	logic homeAccept;
	logic signed [32:0] relTarget;
	logic relOut;
	logic absPp;
	logic [31:0] refStepped;
	logic overtravel;
	logic hwHit;
	logic [15:0] latchSet;

	psl_limit_if lim ();

	psl_sync u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.din({limNegPin_n, limPosPin_n}),
		.dout(pinSync)
	);

	psl_limit_check u_check (
		.clk(clk),
		.sys_rst(sys_rst),
		.lim(lim)
	);

	assign lim.pos = r_reg.refPos;
	assign lim.limPos = r_reg.swlPos;
	assign lim.limNeg = r_reg.swlNeg;
	assign lim.enable = r_reg.swlEnable;
	assign lim.refOk = r_reg.refOk;

	function automatic logic [31:0] step(input logic [31:0] p,
		input logic dir);
		return dir ? p + 32'h00000001 : p - 32'h00000001;
	endfunction : step

	// out-of-range writes clamp toward the limit of their own sign
	function automatic logic [31:0] clampUsr(input logic [31:0] v);
		logic signed [32:0] e;
		e = psl_ext(v);
		if (psl_in_range(e)) begin
			return v;
		end
		return e < POS_MIN ? POS_MIN[31:0] : POS_MAX[31:0];
	endfunction : clampUsr

	assign hwPos = ~pinSync[0];
	assign hwNeg = ~pinSync[1];
	assign homeAccept = homingStart && motorStandstill &&
		(homingMethodSelect == HOME_BY_SET);
	assign relTarget = psl_ext(r_reg.refPos) + psl_ext(moveDistance);
	assign relOut = moveStart && moveRelative && (opMode == PSL_MODE_PP) &&
		!psl_in_range(relTarget);
	assign absPp = (opMode == PSL_MODE_PP) && !moveRelative;
	assign refStepped = step(r_reg.refPos, refDir);
	// crossing out of the range, not merely being out, loses the reference
	assign overtravel = refStep && psl_in_range(psl_ext(r_reg.refPos)) &&
		!psl_in_range(psl_ext(refStepped));
	assign hwHit = refStep && ((refDir && hwPos) || (!refDir && hwNeg));

	always_comb begin
		latchSet = 16'h0000;
		latchSet[LATCH_SW_BIT] = lim.tripPos || lim.tripNeg;
		latchSet[LATCH_HW_BIT] = hwHit;
	end

	always_comb begin
		r_next = r_reg;
		if (ce) begin
			r_next.ack = paramWr || paramRd;
			r_next.err = 1'b0;
			r_next.homeDone = 1'b0;
			r_next.homeRef = homingStart && !homeAccept;
			r_next.zeroSet = 1'b0;
			if (paramWr) begin
				unique case (paramAddr)
					ADDR_SWL_EN: r_next.swlEnable = paramWrData[15:0];
					ADDR_SWL_POS: r_next.swlPos = clampUsr(paramWrData);
					ADDR_SWL_NEG: r_next.swlNeg = clampUsr(paramWrData);
					ADDR_HOME_SET: r_next.homeSet = paramWrData;
					default: r_next.err = 1'b1;
				endcase
			end else if (paramRd) begin
				unique case (paramAddr)
					ADDR_SWL_EN: r_next.rdData = {16'h0000, r_reg.swlEnable};
					ADDR_SWL_POS: r_next.rdData = r_reg.swlPos;
					ADDR_SWL_NEG: r_next.rdData = r_reg.swlNeg;
					ADDR_HOME_SET: r_next.rdData = r_reg.homeSet;
					ADDR_REF_POS: r_next.rdData = r_reg.refPos;
					ADDR_ACT_POS: r_next.rdData = r_reg.actPos;
					ADDR_LATCHED: r_next.rdData = {16'h0000, r_reg.latched};
					default: begin
						r_next.rdData = 32'h00000000;
						r_next.err = 1'b1;
					end
				endcase
			end
			// motor at rest during a set, so steps are not merged here
			if (homeAccept) begin
				r_next.refPos = r_reg.homeSet;
				r_next.actPos = r_reg.actPos - r_reg.refPos +
					r_reg.homeSet;
				r_next.refOk = 1'b1;
				r_next.homeDone = 1'b1;
			end else if (relOut) begin
				r_next.refPos = POS_RST;
				r_next.actPos = r_reg.actPos - r_reg.refPos;
				r_next.refOk = 1'b0;
				r_next.zeroSet = 1'b1;
			end else begin
				if (refStep) begin
					r_next.refPos = refStepped;
				end
				if (actStep) begin
					r_next.actPos = step(r_reg.actPos, actDir);
				end
				if (overtravel) begin
					r_next.refOk = 1'b0;
				end
			end
			// stop outputs are levels: they hold while the cause stands
			r_next.stopPos = lim.tripPos || hwPos ||
				(absPp && psl_ext(r_reg.refPos) >= POS_MAX);
			r_next.stopNeg = lim.tripNeg || hwNeg ||
				(absPp && psl_ext(r_reg.refPos) <= POS_MIN);
			// a new trigger wins over a clear in the same cycle
			r_next.latched = (r_reg.latched & ~latchClear) | latchSet;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			r_reg <= STATE_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	assign paramRdData = r_reg.rdData;
	assign paramAck = r_reg.ack;
	assign paramErr = r_reg.err;
	assign referenceOk = r_reg.refOk;
	assign stopPositive = r_reg.stopPos;
	assign stopNegative = r_reg.stopNeg;
	assign latchedSignalStatus = r_reg.latched;
	assign homingDone = r_reg.homeDone;
	assign homingRefused = r_reg.homeRef;
	assign moveZeroSet = r_reg.zeroSet;

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_homeReq;
		ce && homingStart && motorStandstill &&
			homingMethodSelect == HOME_BY_SET;
	endsequence
	sequence s_relOverrun;
		ce && moveStart && moveRelative && opMode == PSL_MODE_PP &&
			!psl_in_range(relTarget);
	endsequence

	a_home_sets_zero: assert property (
		s_homeReq |=> (r_reg.refPos == $past(r_reg.homeSet)) &&
			r_reg.refOk && homingDone)
		else $error("position setting did not load set value");
	a_home_standstill: assert property (
		ce && homingStart && !motorStandstill |=>
			homingRefused && !homingDone)
		else $error("homing accepted while moving");
	a_home_keeps_dev: assert property (
		s_homeReq |=> (r_reg.refPos - r_reg.actPos) ==
			$past(r_reg.refPos - r_reg.actPos))
		else $error("position setting changed deviation");
	a_ref_readback: assert property (
		ce && paramRd && !paramWr && paramAddr == ADDR_REF_POS |=>
			paramAck && paramRdData == $past(r_reg.refPos))
		else $error("reference position readback wrong");
	a_act_readback: assert property (
		ce && paramRd && !paramWr && paramAddr == ADDR_ACT_POS |=>
			paramAck && paramRdData == $past(r_reg.actPos))
		else $error("motor position readback wrong");
	a_overtravel_lost: assert property (
		ce && overtravel && !homeAccept && !relOut |=> !referenceOk)
		else $error("reference kept after overtravel");
	a_rel_zero: assert property (
		s_relOverrun and !homeAccept |=>
			r_reg.refPos == POS_RST && !referenceOk && moveZeroSet)
		else $error("relative overrun did not zero position");
	a_swl_latch: assert property (
		ce && (lim.tripPos || lim.tripNeg) |=>
			latchedSignalStatus[LATCH_SW_BIT] [*1])
		else $error("soft limit trigger not latched");
	a_swl_clamp: assert property (
		ce && paramWr && paramAddr == ADDR_SWL_POS &&
		psl_ext(paramWrData) > POS_MAX |=> r_reg.swlPos == POS_MAX[31:0])
		else $error("soft limit not clamped");
	a_swl_stop: assert property (
		ce && lim.tripPos |=> stopPositive)
		else $error("soft limit did not stop motion");
	a_hw_stop: assert property (
		ce && hwNeg |=> stopNegative)
		else $error("hardware limit did not stop motion");
	a_swl_neg_stop: assert property (
		ce && lim.tripNeg |=> stopNegative)
		else $error("negative soft limit did not stop motion");
	a_abs_range_stop: assert property (
		ce && absPp && psl_ext(r_reg.refPos) >= POS_MAX |=> stopPositive)
		else $error("absolute move not held at range end");
	a_hw_latch: assert property (
		ce && hwHit |=> latchedSignalStatus[LATCH_HW_BIT])
		else $error("hardware limit hit not latched");
	a_latch_sticky: assert property (
		ce && latchedSignalStatus[LATCH_SW_BIT] &&
		!latchClear[LATCH_SW_BIT] |=> latchedSignalStatus[LATCH_SW_BIT])
		else $error("soft limit flag lost without clear");
endmodule : psl_position_limits

// *** psl_sync.sv ***
/*
 * Two-flop synchroniser for asynchronous pin inputs.
 * Assumes the caller reads only the second stage.
 */
`timescale 1ns/1ns
module psl_sync (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [1:0] din,
	output logic [1:0] dout
);
	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
	} psl_sync_t;

	psl_sync_t r_reg;
	psl_sync_t r_next;

	always_comb begin
		r_next = r_reg;
		if (ce) begin
			r_next.s1 = din;
			r_next.s2 = r_reg.s1;
		end
	end

	// pins idle high (inactive) so the reset value is all ones
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			r_reg <= '{s1: 2'h3, s2: 2'h3};
		end else begin
			r_reg <= r_next;
		end
	end

	assign dout = r_reg.s2;
endmodule : psl_sync

// *** tb_top.sv ***
/* Self-checking bench for the position and limit block.
   Assumes the bus master model in psl_bus_master. */
`timescale 1ns/1ns
module tb_top;
	import psl_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] pA;
	logic [31:0] pW, pQ;
	logic pWr, pRd, pAck, pErr;
	logic [7:0] meth = 8'h00;
	logic hStart = 1'b0, still = 1'b1, mStart = 1'b0, mRel = 1'b0;
	psl_mode_t opMode = PSL_MODE_OTHER;
	logic [31:0] mDist = 32'h00000000;
	logic rS = 1'b0, rD = 1'b1, aS = 1'b0, aD = 1'b1;
	logic limP_n = 1'b1, limN_n = 1'b1;
	logic [15:0] lClr = 16'h0000, latched;
	logic refOk, stopP, stopN, hDone, hRef, zSet;
	int err_total = 0;
	int samples_checked = 0;
	always #50 clk = ~clk;
	psl_position_limits u_psl_position_limits (.clk(clk),
		.sys_rst(sys_rst), .ce(1'b1), .paramAddr(pA),
		.paramWrData(pW), .paramWr(pWr), .paramRd(pRd),
		.paramRdData(pQ), .paramAck(pAck), .paramErr(pErr),
		.homingMethodSelect(meth), .homingStart(hStart),
		.motorStandstill(still), .opMode(opMode), .moveStart(mStart),
		.moveRelative(mRel), .moveDistance(mDist), .refStep(rS),
		.refDir(rD), .actStep(aS), .actDir(aD), .limPosPin_n(limP_n),
		.limNegPin_n(limN_n), .latchClear(lClr), .referenceOk(refOk),
		.stopPositive(stopP), .stopNegative(stopN),
		.latchedSignalStatus(latched), .homingDone(hDone),
		.homingRefused(hRef), .moveZeroSet(zSet));
	psl_bus_master u_psl_bus_master (.clk(clk), .paramAck(pAck),
		.paramErr(pErr), .paramRdData(pQ), .paramAddr(pA),
		.paramWrData(pW), .paramWr(pWr), .paramRd(pRd));
	task automatic final_report();
		$display("compares %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("ERROR at %0t seen %h expected %h", $time, s, e);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic acc(input logic w, input logic [15:0] a,
		input logic [31:0] d, input logic [31:0] q, input logic e);
		logic [31:0] gq;
		logic ge, ok;
		u_psl_bus_master.access(w, a, d, gq, ge, ok);
		if (!ok) begin
			err_total++;
			final_report();
		end
		check(32'(ge), 32'(e));
		if (!w && !e)
			check(gq, q);
	endtask : acc
	task automatic step(input logic r, input logic a, input logic dir,
		input int n);
		@(negedge clk);
		rS = r;
		aS = a;
		rD = dir;
		aD = dir;
		cyc(n);
		rS = 1'b0;
		aS = 1'b0;
	endtask : step
	task automatic home(input logic [7:0] m, input logic s,
		input logic ok);
		@(negedge clk);
		meth = m;
		still = s;
		hStart = 1'b1;
		@(negedge clk);
		hStart = 1'b0;
		check(32'(hDone), 32'(ok));
		check(32'(hRef), 32'(!ok));
	endtask : home
	task automatic t_reset();
		acc(0, ADDR_SWL_EN, 0, 32'h00000000, 0);
		acc(0, ADDR_SWL_POS, 0, 32'h7FFFFFFF, 0);
		acc(0, ADDR_SWL_NEG, 0, 32'h80000000, 0);
		acc(0, ADDR_HOME_SET, 0, 32'h00000000, 0);
		acc(1, ADDR_REF_POS, 32'h00000005, 0, 1);
		acc(0, ADDR_REF_POS, 0, 32'h00000000, 0);
		acc(0, 16'h0001, 0, 0, 1);
	endtask : t_reset
	task automatic t_clamp();
		acc(1, ADDR_SWL_POS, 32'h7FFFFFFF, 0, 0);
		acc(0, ADDR_SWL_POS, 0, 32'h3FFFFFFF, 0);
		acc(1, ADDR_SWL_NEG, 32'h80000000, 0, 0);
		acc(0, ADDR_SWL_NEG, 0, 32'hC0000000, 0);
		acc(1, ADDR_SWL_POS, 32'h00000067, 0, 0);
		acc(0, ADDR_SWL_POS, 0, 32'h00000067, 0);
		acc(1, ADDR_SWL_NEG, 32'hFFFFFF00, 0, 0);
		acc(0, ADDR_SWL_NEG, 0, 32'hFFFFFF00, 0);
	endtask : t_clamp
	task automatic t_homing();
		acc(1, ADDR_HOME_SET, 32'h00000064, 0, 0);
		home(8'h22, 1, 0);
		home(HOME_BY_SET, 0, 0);
		step(1, 1, 1, 1);
		step(1, 0, 1, 2);
		home(HOME_BY_SET, 1, 1);
		check(32'(refOk), 32'h1);
		acc(0, ADDR_REF_POS, 0, 32'h00000064, 0);
		acc(0, ADDR_ACT_POS, 0, 32'h00000062, 0);
	endtask : t_homing
	task automatic t_soft();
		step(1, 1, 1, 3);
		cyc(2);
		check(32'(stopP), 32'h0);
		acc(1, ADDR_SWL_EN, 32'h00000002, 0, 0);
		cyc(2);
		check(32'(stopP), 32'h0);
		acc(1, ADDR_SWL_EN, 32'h00000001, 0, 0);
		cyc(2);
		check(32'(stopP), 32'h1);
		check(32'(stopN), 32'h0);
		acc(0, ADDR_LATCHED, 0, 32'h00000004, 0);
		acc(1, ADDR_SWL_EN, 32'h00000003, 0, 0);
		cyc(2);
		check(32'(stopP), 32'h1);
		acc(1, ADDR_SWL_EN, 32'h00000000, 0, 0);
		@(negedge clk);
		lClr = 16'h0004;
		@(negedge clk);
		lClr = 16'h0000;
		cyc(1);
		check(32'(latched), 32'h0);
	endtask : t_soft
	task automatic t_move();
		@(negedge clk);
		opMode = PSL_MODE_PP;
		mRel = 1'b1;
		mDist = 32'h0000000A;
		mStart = 1'b1;
		@(negedge clk);
		check(32'(zSet), 32'h0);
		mDist = 32'h3FFFFFFF;
		@(negedge clk);
		mStart = 1'b0;
		check(32'(zSet), 32'h1);
		check(32'(refOk), 32'h0);
		opMode = PSL_MODE_OTHER;
		acc(0, ADDR_REF_POS, 0, 32'h00000000, 0);
		acc(0, ADDR_ACT_POS, 0, 32'hFFFFFFFE, 0);
		acc(1, ADDR_SWL_POS, 32'h00000000, 0, 0);
		acc(1, ADDR_SWL_EN, 32'h00000001, 0, 0);
		cyc(2);
		check(32'(stopP), 32'h0);
		acc(1, ADDR_SWL_EN, 32'h00000000, 0, 0);
	endtask : t_move
	task automatic t_over();
		acc(1, ADDR_HOME_SET, 32'h3FFFFFFE, 0, 0);
		home(HOME_BY_SET, 1, 1);
		step(1, 0, 1, 1);
		cyc(1);
		check(32'(refOk), 32'h1);
		step(1, 0, 1, 1);
		cyc(1);
		check(32'(refOk), 32'h0);
		check(32'(stopP), 32'h0);
		// absolute profile moves must not pass the range end
		opMode = PSL_MODE_PP;
		mRel = 1'b0;
		cyc(1);
		check(32'(stopP), 32'h1);
		opMode = PSL_MODE_OTHER;
		cyc(1);
		check(32'(stopP), 32'h0);
	endtask : t_over
	task automatic t_hw();
		@(negedge clk);
		limP_n = 1'b0;
		cyc(4);
		step(1, 0, 1, 1);
		cyc(2);
		check(32'(latched[LATCH_HW_BIT]), 32'h1);
		check(32'(stopP), 32'h1);
		limP_n = 1'b1;
		limN_n = 1'b0;
		cyc(4);
		check(32'(stopP), 32'h0);
		check(32'(stopN), 32'h1);
		check(32'(latched[LATCH_HW_BIT]), 32'h1);
		limN_n = 1'b1;
	endtask : t_hw
	initial begin
		cyc(5);
		sys_rst = 1'b0;
		t_reset();
		t_clamp();
		t_homing();
		t_soft();
		t_move();
		t_over();
		t_hw();
		final_report();
	end
endmodule : tb_top
